// File: pkg/scl_pkg.sv
// Purpose: shared constants and types of the stereo codec link controller
// Assumes: host bus bits numbered with bit 0 as lsb
// Notes:   status and control bit positions are given in that numbering
package scl_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_PLAY  = 8'h00;
  localparam logic [7:0] OFS_REC   = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_FRST  = 8'h0C;
  localparam logic [7:0] OFS_CADDR = 8'h10;
  localparam logic [7:0] OFS_CRD   = 8'h14;
  localparam logic [7:0] OFS_CWD   = 8'h18;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned ST_OVR    = 7;
  localparam int unsigned ST_UNR    = 6;
  localparam int unsigned ST_RDY    = 5;
  localparam int unsigned ST_FIN    = 4;
  localparam int unsigned ST_REMPTY = 3;
  localparam int unsigned ST_RFULL  = 2;
  localparam int unsigned ST_PHALF  = 1;
  localparam int unsigned ST_PFULL  = 0;
  localparam int unsigned FRST_REC  = 1;
  localparam int unsigned FRST_PLAY = 0;
  localparam int unsigned CADDR_RD  = 0;
  localparam int unsigned CADDR_LSB = 1;
  localparam int unsigned TAG_VALID = 15;
  localparam int unsigned TAG_S2    = 13;
  localparam int unsigned TAG_S3    = 12;
  localparam int unsigned TAG_S4    = 11;

  // ------------------------------------------------------------
  // sizes, levels, frame layout, reset values
  // ------------------------------------------------------------
  localparam int unsigned SMP_W      = 16;
  localparam int unsigned FIFO_D     = 16;
  localparam logic [4:0]  HEMPTY_MAX = 5'h07;
  localparam logic [4:0]  HALF_LVL   = 5'h08;
  localparam logic [4:0]  FULL_LVL   = 5'h10;
  localparam logic [2:0]  LVL_EMPTY  = 3'h1;
  localparam logic [2:0]  LVL_HEMPTY = 3'h2;
  localparam logic [2:0]  LVL_HFULL  = 3'h3;
  localparam logic [2:0]  LVL_FULL   = 3'h4;
  localparam logic [2:0]  PLAY_LVL   = 3'h2;
  localparam logic [2:0]  REC_LVL    = 3'h3;
  localparam logic [4:0]  SLOT0_LAST = 5'h0F;
  localparam logic [4:0]  SLOTN_LAST = 5'h13;
  localparam logic [3:0]  SLOT_TAG   = 4'h0;
  localparam logic [3:0]  SLOT_CADDR = 4'h1;
  localparam logic [3:0]  SLOT_CDATA = 4'h2;
  localparam logic [3:0]  SLOT_LEFT  = 4'h3;
  localparam logic [3:0]  SLOT_RIGHT = 4'h4;
  localparam logic [3:0]  SLOT_END   = 4'hC;
  localparam logic        FIN_RST    = 1'b1;

  typedef enum logic [1:0] {
    CMD_IDLE   = 2'b00,
    CMD_QUEUED = 2'b01,
    CMD_SENT   = 2'b10
  } scl_cmd_t;

endpackage

// File: rtl/scl_ctrl.sv
// Purpose: stereo codec link controller, register slave and serial link
// Assumes: bus bit 0 is lsb; bit clock sampled by sys_clk_in
// Notes:   one stereo pair per link frame in each direction
`timescale 1ns/1ps
module scl_ctrl #(
  parameter logic [31:0] BASE_ADDR  = 32'h0000_0000,
  parameter logic [2:0]  PLAY_LEVEL = scl_pkg::PLAY_LVL,
  parameter logic [2:0]  REC_LEVEL  = scl_pkg::REC_LVL
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [31:0] bus_addr_in,
  input  wire logic [3:0]  bus_be_in,
  input  wire logic [31:0] bus_wdata_in,
  input  wire logic        bus_rnw_in,
  input  wire logic        bus_sel_in,
  input  wire logic        bus_seq_addr_in,
  output logic [31:0]      bus_rdata_out,
  output logic             bus_xfer_ack_out,
  output logic             bus_err_ack_out,
  output logic             bus_retry_out,
  output logic             bus_tout_sup_out,
  output logic             play_irq_out,
  output logic             rec_irq_out,
  input  wire logic        bit_clk_in,
  output logic             sync_out,
  output logic             sdata_out,
  input  wire logic        sdata_in
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic              bclk_s1;
    logic              bclk_s2;
    logic              bclk_s3;
    logic              sdin_s1;
    logic              sdin_s2;
    logic              ack;
    logic              err;
    logic              tout;
    logic [31:0]       rdata;
    scl_pkg::scl_cmd_t cmd;
    logic              cmd_rd;
    logic [6:0]        cmd_addr;
    logic [15:0]       cmd_wdata;
    logic [15:0]       cmd_rdata;
    logic              fin;
    logic              frame_cmd;
    logic              unr;
    logic              ovr;
    logic              ready;
    logic [15:0]       rx_tag;
    logic [3:0]        slot;
    logic [4:0]        bidx;
    logic [19:0]       tsh;
    logic [3:0]        lag_slot;
    logic [4:0]        lag_bidx;
    logic [3:0]        rx_slot;
    logic [4:0]        rx_bidx;
    logic              retry;
    logic [19:0]       rsh;
    logic              play_ok;
    logic [1:0]        pop_pend;
    logic [15:0]       play_l;
    logic [15:0]       play_r;
    logic [1:0]        push_pend;
    logic [15:0]       rec_l;
    logic [15:0]       rec_r;
    logic              sync;
    logic              sdo;
    logic              pirq;
    logic              rirq;
  } scl_state_t;

  scl_state_t  q;
  scl_state_t  d;
  logic        rise;
  logic        fall;
  logic [19:0] rx_word;
  logic        bus_req;
  logic [7:0]  bus_ofs;
  logic        caddr_wr;
  logic [31:0] status;
  logic        pf_push;
  logic        pf_clr;
  logic        pf_in_ready;
  logic        pf_valid;
  logic [15:0] pf_data;
  logic [4:0]  pf_cnt;
  logic        rf_pop;
  logic        rf_clr;
  logic        rf_in_ready;
  logic        rf_valid;
  logic [15:0] rf_data;
  logic [15:0] rf_din;
  logic [4:0]  rf_cnt;
  logic        unr_set;
  logic        ovr_set;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [4:0] slot_last(input logic [3:0] slot);
    slot_last = (slot == scl_pkg::SLOT_TAG) ? scl_pkg::SLOT0_LAST : scl_pkg::SLOTN_LAST;
  endfunction

  function automatic logic lvl_hit(input logic [4:0] cnt, input logic [2:0] lvl);
    case (lvl)
      scl_pkg::LVL_EMPTY:  lvl_hit = (cnt == 5'h00);
      scl_pkg::LVL_HEMPTY: lvl_hit = (cnt <= scl_pkg::HEMPTY_MAX);
      scl_pkg::LVL_HFULL:  lvl_hit = (cnt >= scl_pkg::HALF_LVL);
      scl_pkg::LVL_FULL:   lvl_hit = (cnt == scl_pkg::FULL_LVL);
      default:             lvl_hit = 1'b0;
    endcase
  endfunction

  // edges only valid while the system clock is over twice the bit clock
  assign rise     = q.bclk_s2 & ~q.bclk_s3;
  assign fall     = ~q.bclk_s2 & q.bclk_s3;
  assign rx_word  = {q.rsh[18:0], q.sdin_s2};
  assign bus_ofs  = bus_addr_in[7:0];
  assign bus_req  = bus_sel_in & (bus_addr_in[31:8] == BASE_ADDR[31:8]) & ~q.ack & ~q.err;
  assign caddr_wr = bus_req & ~bus_rnw_in & (bus_ofs == scl_pkg::OFS_CADDR);
  assign unr_set  = (q.pop_pend != 2'h0) & ~pf_valid;
  assign ovr_set  = (q.push_pend != 2'h0) & ~rf_in_ready;
  assign rf_din   = (q.push_pend == 2'h2) ? q.rec_l : q.rec_r;

  // ------------------------------------------------------------
  // sample queues
  // ------------------------------------------------------------
  scl_fifo #(
    .WIDTH (scl_pkg::SMP_W),
    .DEPTH (scl_pkg::FIFO_D)
  ) u_play_fifo (
    .clk_in        (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .clear_in      (pf_clr),
    .in_valid_in   (pf_push),
    .in_ready_out  (pf_in_ready),
    .in_data_in    (bus_wdata_in[15:0]),
    .out_valid_out (pf_valid),
    .out_ready_in  (q.pop_pend != 2'h0),
    .out_data_out  (pf_data),
    .count_out     (pf_cnt)
  );

  scl_fifo #(
    .WIDTH (scl_pkg::SMP_W),
    .DEPTH (scl_pkg::FIFO_D)
  ) u_rec_fifo (
    .clk_in        (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .clear_in      (rf_clr),
    .in_valid_in   (q.push_pend != 2'h0),
    .in_ready_out  (rf_in_ready),
    .in_data_in    (rf_din),
    .out_valid_out (rf_valid),
    .out_ready_in  (rf_pop),
    .out_data_out  (rf_data),
    .count_out     (rf_cnt)
  );

  always_comb begin
    status                     = 32'h0000_0000;
    status[scl_pkg::ST_OVR]    = q.ovr;
    status[scl_pkg::ST_UNR]    = q.unr;
    status[scl_pkg::ST_RDY]    = q.ready;
    status[scl_pkg::ST_FIN]    = q.fin;
    status[scl_pkg::ST_REMPTY] = ~rf_valid;
    status[scl_pkg::ST_RFULL]  = ~rf_in_ready;
    status[scl_pkg::ST_PHALF]  = (pf_cnt >= scl_pkg::HALF_LVL);
    status[scl_pkg::ST_PFULL]  = ~pf_in_ready;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d         = q;
    pf_push   = 1'b0;
    pf_clr    = 1'b0;
    rf_pop    = 1'b0;
    rf_clr    = 1'b0;
    d.bclk_s1 = bit_clk_in;
    d.bclk_s2 = q.bclk_s1;
    d.bclk_s3 = q.bclk_s2;
    d.sdin_s1 = sdata_in;
    d.sdin_s2 = q.sdin_s1;
    d.pirq    = lvl_hit(pf_cnt, PLAY_LEVEL);
    d.rirq    = lvl_hit(rf_cnt, REC_LEVEL);

    // one left/right pair taken per frame, so both channels share a rate
    if (q.pop_pend != 2'h0) begin
      if (q.pop_pend == 2'h2) begin
        d.play_l = pf_valid ? pf_data : 16'h0000;
      end else begin
        d.play_r = pf_valid ? pf_data : 16'h0000;
      end
      if (unr_set) d.unr = 1'b1;
      d.pop_pend = q.pop_pend - 2'h1;
    end

    if (q.push_pend != 2'h0) begin
      if (ovr_set) d.ovr = 1'b1;
      d.push_pend = q.push_pend - 2'h1;
    end

    if (rise) begin
      d.sdo     = q.tsh[19];
      d.sync    = (q.slot == scl_pkg::SLOT_TAG);
      // codec answers on the first bit clock rise after sync is raised, so input lags output by a bit
      d.lag_slot = q.slot;
      d.lag_bidx = q.bidx;
      d.rx_slot  = q.lag_slot;
      d.rx_bidx  = q.lag_bidx;
      d.tsh     = {q.tsh[18:0], 1'b0};
      d.bidx    = q.bidx + 5'h01;
      if (q.bidx == slot_last(q.slot)) begin
        d.bidx = 5'h00;
        d.slot = (q.slot == scl_pkg::SLOT_END) ? scl_pkg::SLOT_TAG : q.slot + 4'h1;
        case (d.slot)
          scl_pkg::SLOT_TAG: begin
            // a write is done once the frame that carried it has ended
            if (q.cmd == scl_pkg::CMD_SENT && !q.cmd_rd) begin
              d.fin = 1'b1;
              d.cmd = scl_pkg::CMD_IDLE;
            end
            d.frame_cmd = (q.cmd == scl_pkg::CMD_QUEUED);
            if (d.frame_cmd) d.cmd = scl_pkg::CMD_SENT;
            d.play_ok  = q.ready;
            d.pop_pend = q.ready ? 2'h2 : 2'h0;
            d.tsh = {1'b1, d.frame_cmd, d.frame_cmd & ~q.cmd_rd, q.ready, q.ready, 15'h0000};
          end
          scl_pkg::SLOT_CADDR: begin
            d.tsh = q.frame_cmd ? {q.cmd_rd, q.cmd_addr, 12'h000} : 20'h00000;
          end
          scl_pkg::SLOT_CDATA: begin
            d.tsh = (q.frame_cmd && !q.cmd_rd) ? {q.cmd_wdata, 4'h0} : 20'h00000;
          end
          scl_pkg::SLOT_LEFT: begin
            d.tsh = q.play_ok ? {q.play_l, 4'h0} : 20'h00000;
          end
          scl_pkg::SLOT_RIGHT: begin
            d.tsh = q.play_ok ? {q.play_r, 4'h0} : 20'h00000;
          end
          default: begin
            d.tsh = 20'h00000;
          end
        endcase
      end
    end

    if (fall) begin
      d.rsh = rx_word;
      if (q.rx_bidx == slot_last(q.rx_slot)) begin
        case (q.rx_slot)
          scl_pkg::SLOT_TAG: begin
            d.rx_tag = rx_word[15:0];
            d.ready  = rx_word[scl_pkg::TAG_VALID];
          end
          scl_pkg::SLOT_CDATA: begin
            if (q.cmd == scl_pkg::CMD_SENT && q.cmd_rd && q.rx_tag[scl_pkg::TAG_S2]) begin
              d.cmd_rdata = rx_word[19:4];
              d.fin       = 1'b1;
              d.cmd       = scl_pkg::CMD_IDLE;
            end
          end
          scl_pkg::SLOT_LEFT: begin
            d.rec_l = rx_word[19:4];
          end
          scl_pkg::SLOT_RIGHT: begin
            if (q.rx_tag[scl_pkg::TAG_S3] && q.rx_tag[scl_pkg::TAG_S4]) begin
              d.rec_r     = rx_word[19:4];
              d.push_pend = 2'h2;
            end
          end
          default: begin
            d.rsh = rx_word;
          end
        endcase
      end
    end

    // host bus slave, one-cycle acknowledge except a playback write to a full queue, which waits
    d.ack   = 1'b0;
    d.err   = 1'b0;
    d.tout  = 1'b0;
    d.rdata = 32'h0000_0000;
    if (bus_req) begin
      if (bus_rnw_in) begin
        if (bus_ofs == scl_pkg::OFS_REC) begin
          d.ack         = 1'b1;
          rf_pop        = rf_valid;
          d.rdata[15:0] = rf_valid ? rf_data : 16'h0000;
        end else if (bus_ofs == scl_pkg::OFS_STAT) begin
          d.ack   = 1'b1;
          d.rdata = status;
        end else if (bus_ofs == scl_pkg::OFS_CRD) begin
          d.ack         = 1'b1;
          d.rdata[15:0] = q.cmd_rdata;
        end else begin
          d.err = 1'b1;
        end
      end else begin
        if (bus_ofs == scl_pkg::OFS_PLAY) begin
          // full queue stalls the bus instead of dropping a sample
          d.ack   = pf_in_ready;
          d.tout  = ~pf_in_ready;
          pf_push = pf_in_ready;
        end else if (bus_ofs == scl_pkg::OFS_FRST) begin
          d.ack  = 1'b1;
          pf_clr = bus_wdata_in[scl_pkg::FRST_PLAY];
          rf_clr = bus_wdata_in[scl_pkg::FRST_REC];
          if (pf_clr) d.unr = unr_set;
          if (rf_clr) d.ovr = ovr_set;
        end else if (bus_ofs == scl_pkg::OFS_CADDR) begin
          d.ack      = 1'b1;
          d.cmd_addr = bus_wdata_in[scl_pkg::CADDR_LSB +: 7];
          d.cmd_rd   = bus_wdata_in[scl_pkg::CADDR_RD];
          d.cmd      = scl_pkg::CMD_QUEUED;
          d.fin      = 1'b0;
        end else if (bus_ofs == scl_pkg::OFS_CWD) begin
          d.ack       = 1'b1;
          d.cmd_wdata = bus_wdata_in[15:0];
        end else begin
          d.err = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q     <= '0;
      q.fin <= scl_pkg::FIN_RST;
    end else begin
      q <= d;
    end
  end

  assign bus_rdata_out    = q.rdata;
  assign bus_xfer_ack_out = q.ack;
  assign bus_err_ack_out  = q.err;
  assign bus_retry_out    = q.retry;
  assign bus_tout_sup_out = q.tout;
  assign play_irq_out     = q.pirq;
  assign rec_irq_out      = q.rirq;
  assign sync_out         = q.sync;
  assign sdata_out        = q.sdo;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_underrun_cause: assert property ($rose(q.unr) |-> $past(unr_set))
    else $error("underrun without empty request");
  a_underrun_sticky: assert property (q.unr && !pf_clr |=> q.unr)
    else $error("underrun dropped without reset");
  a_overrun_cause: assert property ($rose(q.ovr) |-> $past(ovr_set))
    else $error("overrun without full push");
  a_overrun_sticky: assert property (q.ovr && !rf_clr |=> q.ovr)
    else $error("overrun dropped without reset");
  a_pop_order: assert property (q.pop_pend == 2'h2 |=> q.pop_pend == 2'h1 ##1 q.pop_pend == 2'h0)
    else $error("playback pair not taken in order");
  a_push_order: assert property (q.push_pend == 2'h2 |-> rf_din == q.rec_l ##1 rf_din == q.rec_r)
    else $error("record pair not pushed left first");
  a_fin_clear: assert property (caddr_wr |=> !q.fin && q.cmd == scl_pkg::CMD_QUEUED)
    else $error("address write left finish set");
  a_read_done: assert property ($rose(q.fin) && q.cmd_rd |-> $past(fall))
    else $error("read finished outside slot capture");
  a_play_push: assert property (bus_req && !bus_rnw_in && bus_ofs == 8'h00 && pf_in_ready
    |-> pf_push ##1 bus_xfer_ack_out) else $error("playback write not taken");
  a_rec_pop: assert property (bus_req && bus_rnw_in && bus_ofs == 8'h04 && rf_valid
    |=> bus_xfer_ack_out && bus_rdata_out[15:0] == $past(rf_data)) else $error("record read wrong");
  a_stat_play: assert property (bus_req && bus_rnw_in && bus_ofs == 8'h08
    |=> bus_rdata_out[0] == $past(!pf_in_ready)) else $error("playback full bit wrong");
  a_stat_rec: assert property (bus_req && bus_rnw_in && bus_ofs == 8'h08
    |=> bus_rdata_out[3] == $past(!rf_valid)) else $error("record empty bit wrong");
  a_sync_edge: assert property ($changed(sync_out) |-> $past(rise))
    else $error("sync moved off a bit clock edge");

  c_underrun: cover property ($rose(q.unr));
  c_overrun: cover property ($rose(q.ovr));
  c_read_done: cover property (caddr_wr ##[1:1000] $rose(q.fin));
  c_play_push: cover property (pf_push ##1 bus_xfer_ack_out);

endmodule

// File: rtl/scl_fifo.sv
// Purpose: sample queue with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   clear_in empties the queue in one cycle
`timescale 1ns/1ps
module scl_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   clear_in,
  input  wire logic                   in_valid_in,
  output logic                        in_ready_out,
  input  wire logic [WIDTH-1:0]       in_data_in,
  output logic                        out_valid_out,
  input  wire logic                   out_ready_in,
  output logic [WIDTH-1:0]            out_data_out,
  output logic [$clog2(DEPTH):0]      count_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } scl_fifo_st_t;

  scl_fifo_st_t     q;
  scl_fifo_st_t     d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_out  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out  = mem[q.rd];
  assign count_out     = q.cnt;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_comb begin
    d = q;
    if (clear_in) begin
      d = '0;
    end else begin
      if (push) d.wr = q.wr + 1'b1;
      if (pop) d.rd = q.rd + 1'b1;
      d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // no reset on storage: contents are only read behind the counter
  always_ff @(posedge clk_in) begin
    if (push) mem[q.wr] <= in_data_in;
  end

  a_fifo_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule

// File: testbench/scl_codec_model.sv
// Purpose: behavioural codec on the serial link
// Assumes: bit clock runs free; a frame starts where sync is first seen high
// Notes:   a register read is answered in the frame after the request
`timescale 1ns/1ps
module scl_codec_model (
  input  wire logic   sync_in,
  input  wire logic   sdata_in,
  output logic        bit_clk_out,
  output logic        sdata_out,
  output logic        play_stb_out,
  output logic [15:0] play_l_out,
  output logic [15:0] play_r_out
);
  logic [255:0] rx_q = '0;
  logic [255:0] tx_q = '0;
  logic [7:0]   cnt_q = 8'h00;
  logic         sync_q = 1'b0;
  initial begin
    bit_clk_out = 1'b0;
    sdata_out = 1'b0;
    play_stb_out = 1'b0;
  end
  // ------------------------------------------------------------
  // frame engine, drives on the rise, controller samples on the fall
  // ------------------------------------------------------------
  always #62.5 bit_clk_out = ~bit_clk_out;
  always @(posedge bit_clk_out) begin
    play_stb_out = 1'b0;
    cnt_q = cnt_q + 8'h01;
    if (sync_in && !sync_q) begin
      cnt_q = 8'h00;
      play_l_out = rx_q[199:184];
      play_r_out = rx_q[179:164];
      play_stb_out = rx_q[252] & rx_q[251];
      tx_q = '0;
      // ready plus both channels every frame: one common rate
      tx_q[255:251] = 5'h13;
      tx_q[199:184] = 16'hC35A;
      tx_q[179:164] = 16'h5AC3;
      if (rx_q[254] && rx_q[239]) begin
        tx_q[254:253] = 2'h3;
        tx_q[239:220] = rx_q[239:220];
        tx_q[219:204] = {1'b0, rx_q[238:232], 8'h3C};
      end
    end
    rx_q[8'hFF - cnt_q] = sdata_in;
    sdata_out = tx_q[8'hFF - cnt_q];
    sync_q = sync_in;
  end
endmodule

// File: testbench/tb.sv
// Purpose: self-checking bench of the stereo codec link controller
// Assumes: one bus request at a time, answered within the wait bound
// Notes:   bus replies and played pairs are checked against queued notes
`timescale 1ns/1ps
module tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rnw = 1'b1;
  logic        sel = 1'b0;
  logic        sup = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd;
  logic        ack, err, tout, pirq, rirq, bclk, sync, sdo, sdi, pstb, rty;
  logic [15:0] pl, pr, el, er, w;
  logic [6:0]  idx;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [15:0] play_q[$];
  int          errors = 0;
  int          tests_run = 0;
  int          seed = 77206;
  scl_ctrl DUT (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .bus_addr_in(addr), .bus_be_in(4'hF),
    .bus_wdata_in(wdata), .bus_rnw_in(rnw), .bus_sel_in(sel), .bus_seq_addr_in(1'b0),
    .bus_rdata_out(rdata), .bus_xfer_ack_out(ack), .bus_err_ack_out(err), .bus_retry_out(rty),
    .bus_tout_sup_out(tout), .play_irq_out(pirq), .rec_irq_out(rirq), .bit_clk_in(bclk),
    .sync_out(sync), .sdata_out(sdo), .sdata_in(sdi));
  scl_codec_model codec (.sync_in(sync), .sdata_in(sdo), .bit_clk_out(bclk), .sdata_out(sdi),
    .play_stb_out(pstb), .play_l_out(pl), .play_r_out(pr));
  always #2 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // bus driver, closing task, reply monitors
  // ------------------------------------------------------------
  task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                     input logic [31:0] m);
    int n;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(negedge sys_clk);
    rnw = r;
    addr = {24'h0, a};
    wdata = d;
    sel = 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (n == 3) sup = tout;
    end while (!(ack === 1'b1 || err === 1'b1) && n < 20000);
    rd = rdata;
    @(negedge sys_clk);
    sel = 1'b0;
    addr = $random(seed);
    wdata = $random(seed);
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do begin
      bus(1'b1, 8'h08, 32'h0, 33'h0, 32'h0);
      k++;
    end while ((rd & m) !== v && k < 40000);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk) if (rst_n && (ack === 1'b1 || err === 1'b1)) begin
    tests_run++;
    if (exp_q.size() == 0 || rty !== 1'b0 || {err, rdata & msk_q[0]} !== (exp_q[0] & {1'b1, msk_q[0]})) begin
      errors++;
      $display("unexpected %0t bus reply %h", $time, rdata);
    end
    if (exp_q.size() > 0) begin
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  // an empty playback queue sends zero samples
  always @(posedge pstb) begin
    tests_run++;
    el = (play_q.size() > 0) ? play_q.pop_front() : 16'h0000;
    er = (play_q.size() > 0) ? play_q.pop_front() : 16'h0000;
    if (pl !== el || pr !== er) begin
      errors++;
      $display("unexpected %0t played pair %h %h", $time, pl, pr);
    end
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    $display("unexpected %0t watchdog expired", $time);
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    bus(1'b1, 8'h08, 32'h0, 33'h18, 32'hFF);
    tests_run++;
    if (pirq !== 1'b1 || rirq !== 1'b0) begin
      errors++;
      $display("unexpected %0t interrupt levels after reset", $time);
    end
    bus(1'b1, 8'h20, 32'h0, 33'h1_0000_0000, 32'h0);
    bus(1'b0, 8'h08, 32'h0, 33'h1_0000_0000, 32'h0);
    for (int i = 0; i < 18; i++) begin
      w = $random(seed);
      play_q.push_back(w);
      bus(1'b0, 8'h00, {~w, w}, 33'h0, 32'h0);
      if (i == 7) bus(1'b1, 8'h08, 32'h0, 33'h2, 32'h3);
      if (i == 15) bus(1'b1, 8'h08, 32'h0, 33'h3, 32'h3);
      if (i == 15) tests_run++;
      if (i == 15 && pirq !== 1'b0) begin
        errors++;
        $display("unexpected %0t playback interrupt on full queue", $time);
      end
    end
    tests_run++;
    if (sup !== 1'b1) begin
      errors++;
      $display("unexpected %0t no stall on full queue", $time);
    end
    idx = $random(seed);
    bus(1'b0, 8'h18, $random(seed), 33'h0, 32'h0);
    bus(1'b0, 8'h10, {24'h0, idx, 1'b0}, 33'h0, 32'h0);
    bus(1'b1, 8'h08, 32'h0, 33'h0, 32'h10);
    poll(32'h10, 32'h10);
    bus(1'b0, 8'h10, {24'h0, idx, 1'b1}, 33'h0, 32'h0);
    bus(1'b1, 8'h08, 32'h0, 33'h0, 32'h10);
    poll(32'h10, 32'h10);
    bus(1'b1, 8'h14, 32'h0, {18'h0, idx, 8'h3C}, 32'hFFFF);
    poll(32'h20, 32'h20);
    poll(32'h4, 32'h4);
    tests_run++;
    if (rirq !== 1'b1) begin
      errors++;
      $display("unexpected %0t record interrupt missing", $time);
    end
    poll(32'h80, 32'h80);
    for (int i = 0; i < 16; i++) bus(1'b1, 8'h04, 32'h0, (i % 2) ? 33'h5AC3 : 33'hC35A, 32'hFFFF);
    bus(1'b1, 8'h08, 32'h0, 33'h88, 32'h8C);
    bus(1'b0, 8'h0C, 32'h2, 33'h0, 32'h0);
    bus(1'b1, 8'h08, 32'h0, 33'h08, 32'h8C);
    poll(32'h40, 32'h40);
    bus(1'b0, 8'h0C, 32'h1, 33'h0, 32'h0);
    bus(1'b1, 8'h08, 32'h0, 33'h0, 32'h43);
    tally_and_finish();
  end
endmodule
